// ==== logic/dial_pkg.sv ====
`default_nettype none
package dial_pkg;
  // Frame layout: command byte then a 16-bit data field
  localparam int          FRAME_BITS = 24;
  localparam logic [4:0]  FRAME_CNT  = 5'h18;
  localparam logic [4:0]  CNT_MAX    = 5'h1F;
  // Wiper code: 1024 taps, code zero at the low end
  localparam int          WIPER_W    = 10;
  localparam logic [9:0]  WIPER_FULL = 10'h3FF;
  localparam logic [9:0]  WIPER_MID  = 10'h200;
  localparam logic [9:0]  WIPER_RST  = 10'h000;
  // Factory contents of the nonvolatile store after power-on
  localparam logic [9:0]  NV_WIPER_RST = 10'h200;
  localparam logic [15:0] NV_USER_RST  = 16'h0000;
  // User words start at address 2
  localparam logic [3:0]  USER_BASE  = 4'h2;
  localparam int          USER_WORDS = 13;
  // Synchroniser reset: sclk, cs_n, sdi, write protect, restore strobe
  localparam logic [4:0]  SYNC_RST   = 5'h0B;
  localparam logic [2:0]  PREV_RST   = 3'h3;
  // Instruction codes
  localparam logic [3:0]  CMD_NOP        = 4'h0;
  localparam logic [3:0]  CMD_RESTORE    = 4'h1;
  localparam logic [3:0]  CMD_STORE      = 4'h2;
  localparam logic [3:0]  CMD_STORE_USER = 4'h3;
  localparam logic [3:0]  CMD_READ_NV    = 4'h9;
  localparam logic [3:0]  CMD_READ_WIPER = 4'hA;
  localparam logic [3:0]  CMD_WRITE      = 4'hB;
  localparam logic [3:0]  CMD_DOUBLE     = 4'hC;
  localparam logic [3:0]  CMD_INC        = 4'hE;

  // One received command frame, MSB first on the wire
  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  addr;
    logic [15:0] data;
  } frame_t;
endpackage
`default_nettype wire

// ==== logic/dual_wiper_serial_command_decoder.sv ====
// Summary of operation
// - Frame is command byte plus 16-bit data.
// - Output echoes previous frame unless readback prepared.
// - Code B loads 10-bit wiper value.
// - Code E increments addressed wiper by one.
// - Code 2 stores wiper into its slot.
// - Write protect low blocks all nonvolatile writes.
// - Restore at power-on, strobe, or command.
// - Code 1 reloads wiper from its slot.
// - Code C doubles the addressed wiper.
// - Doubling midscale saturates to full scale.
// - Code 3 writes a user word.
// - Code 9 prepares nonvolatile word readback.
// - No-op leaves the read power state.
// - Code A prepares wiper value readback.
// - Wiper holds a 10-bit tap code.
`default_nettype none
module dual_wiper_serial_command_decoder #(
  parameter int USER_WORDS = dial_pkg::USER_WORDS
) (
  // System
  input  wire logic        clock,
  input  wire logic        rst,
  // Serial link from the host
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  // Control pins
  input  wire logic        write_protect_n,
  input  wire logic        restore_strobe_n,
  // Wiper settings and power state
  output logic [9:0]       wiper_terminal_ch1,
  output logic [9:0]       wiper_terminal_ch2,
  output logic             read_power
);

  // Pin synchronisers and edge history
  logic [4:0]  pins_w;                  // Raw pins
  logic [4:0]  sync1_r;                 // First stage, read by stage two only
  logic [4:0]  sync2_r;                 // Stable copies
  logic [2:0]  prev_r;                  // Last sclk, cs_n, strobe
  logic        sclk_s, cs_s, sdi_s;     // Synchronised link
  logic        wp_ok, pr_s;             // Synchronised control pins
  logic        sclk_rise, sclk_fall;    // Link clock edges
  logic        cs_fall, cs_rise;        // Frame start and end
  logic        pr_fall;                 // Restore strobe edge

  // Frame capture
  logic [4:0]  cnt_r, cnt_nxt;          // Rising sclk count in frame
  logic [23:0] in_r, in_nxt;            // Receive shift register
  dial_pkg::frame_t frm;                // Received frame fields
  logic        exec;                    // Frame accepted this cycle
  logic        boot_r;                  // Power-on restore pending
  logic        restore_all;             // Reload both wipers

  // Wipers and nonvolatile store
  logic [9:0]  wiper_r [2];             // Live wiper codes
  logic [9:0]  wiper_nxt [2];
  logic [9:0]  nv_wiper_r [2];          // Stored wiper slots
  logic [9:0]  nv_wiper_nxt [2];
  logic [1:0]  sel_w;                   // Channel addressed
  logic [15:0] nv_user_r [USER_WORDS];  // User words
  logic [3:0]  user_idx;                // Address minus user base
  logic        user_ok;                 // Address names a user word
  logic        user_wr;                 // User word write this cycle

  // Readback and output shift
  logic [15:0] rb_word;                 // Word for a prepared readback
  logic        rb_cmd;                  // Frame asks for readback
  logic [23:0] out_frame_r, out_frame_nxt; // Next frame to send
  logic [23:0] out_r, out_nxt;          // Transmit shift register
  logic        sdo_r;                   // Serial data out flop
  logic        read_power_r, read_power_nxt;

  assign pins_w = {sclk, cs_n, sdi, write_protect_n, restore_strobe_n};

  // Two-stage synchroniser; edges compare stage two with its delay
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_r <= dial_pkg::SYNC_RST;
      sync2_r <= dial_pkg::SYNC_RST;
      prev_r  <= dial_pkg::PREV_RST;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
      prev_r  <= {sync2_r[4], sync2_r[3], sync2_r[0]};
    end
  end

  assign sclk_s    = sync2_r[4];
  assign cs_s      = sync2_r[3];
  assign sdi_s     = sync2_r[2];
  assign wp_ok     = sync2_r[1];
  assign pr_s      = sync2_r[0];
  assign sclk_rise = sclk_s & ~prev_r[2];
  assign sclk_fall = ~sclk_s & prev_r[2];
  assign cs_fall   = ~cs_s & prev_r[1];
  assign cs_rise   = cs_s & ~prev_r[1];
  assign pr_fall   = ~pr_s & prev_r[0];

  // Bits enter MSB first on rising sclk; counter saturates on long frames
  assign cnt_nxt = cs_fall ? 5'h00 :
                   (sclk_rise && !cs_s && cnt_r != dial_pkg::CNT_MAX) ?
                   cnt_r + 5'h01 : cnt_r;
  assign in_nxt  = (sclk_rise && !cs_s) ? {in_r[22:0], sdi_s} : in_r;
  assign frm     = dial_pkg::frame_t'(in_r);
  // Short or long frames are dropped whole
  assign exec    = cs_rise && cnt_r == dial_pkg::FRAME_CNT;
  // Power-on and the strobe pin reload both channels
  assign restore_all = boot_r | pr_fall;

  // Frame capture registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r  <= 5'h00;
      in_r   <= 24'h000000;
      boot_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_nxt;
      in_r   <= in_nxt;
      boot_r <= 1'b0;
    end
  end

  // Per-channel wiper arithmetic and slot update
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [9:0] inc_w;                  // Saturating +1
    logic [9:0] dbl_w;                  // Saturating x2
    assign sel_w[ch] = frm.addr == 4'(ch);
    assign inc_w = (wiper_r[ch] == dial_pkg::WIPER_FULL) ?
                   dial_pkg::WIPER_FULL :
                   wiper_r[ch] + 10'h001;
    // Midscale doubles to full scale rather than wrapping to zero
    assign dbl_w = wiper_r[ch][9] ? dial_pkg::WIPER_FULL :
                   {wiper_r[ch][8:0], 1'b0};
    assign wiper_nxt[ch] =
      restore_all ? nv_wiper_r[ch] :
      !(exec && sel_w[ch]) ? wiper_r[ch] :
      (frm.cmd == dial_pkg::CMD_WRITE)   ? frm.data[9:0] :
      (frm.cmd == dial_pkg::CMD_INC)     ? inc_w :
      (frm.cmd == dial_pkg::CMD_DOUBLE)  ? dbl_w :
      (frm.cmd == dial_pkg::CMD_RESTORE) ? nv_wiper_r[ch] :
      wiper_r[ch];
    assign nv_wiper_nxt[ch] =
      (exec && sel_w[ch] && wp_ok && frm.cmd == dial_pkg::CMD_STORE) ?
      wiper_r[ch] : nv_wiper_r[ch];

    // Nonvolatile slot resets to factory content, not to a live value
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        wiper_r[ch]    <= dial_pkg::WIPER_RST;
        nv_wiper_r[ch] <= dial_pkg::NV_WIPER_RST;
      end else begin
        wiper_r[ch]    <= wiper_nxt[ch];
        nv_wiper_r[ch] <= nv_wiper_nxt[ch];
      end
    end
  end

  // User word decode
  assign user_idx = frm.addr - dial_pkg::USER_BASE;
  assign user_ok  = frm.addr >= dial_pkg::USER_BASE &&
                    user_idx < 4'(USER_WORDS);
  assign user_wr  = exec && wp_ok && user_ok &&
                    frm.cmd == dial_pkg::CMD_STORE_USER;

  // User words, one register each
  for (genvar i = 0; i < USER_WORDS; i++) begin : g_user
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        nv_user_r[i] <= dial_pkg::NV_USER_RST;
      end else if (user_wr && user_idx == 4'(i)) begin
        nv_user_r[i] <= frm.data;
      end
    end
  end

  // Readback word; unmapped addresses read as zero
  assign rb_word =
    (frm.cmd == dial_pkg::CMD_READ_NV) ?
      ((frm.addr < 4'h2) ? {6'h00, nv_wiper_r[frm.addr[0]]} :
       user_ok ? nv_user_r[user_idx] : 16'h0000) :
    (frm.addr < 4'h2) ? {6'h00, wiper_r[frm.addr[0]]} :
    16'h0000;
  assign rb_cmd = frm.cmd == dial_pkg::CMD_READ_NV ||
                  frm.cmd == dial_pkg::CMD_READ_WIPER;
  assign out_frame_nxt = !exec ? out_frame_r :
                         rb_cmd ? {frm.cmd, frm.addr, rb_word} :
                         in_r;
  // Restore commands and readbacks raise power until a no-op
  assign read_power_nxt =
    !exec ? read_power_r :
    (frm.cmd == dial_pkg::CMD_NOP) ? 1'b0 :
    (rb_cmd || frm.cmd == dial_pkg::CMD_RESTORE) ? 1'b1 :
    read_power_r;
  // Load at frame start, shift on falling sclk so the host samples on rise
  assign out_nxt = cs_fall ? out_frame_r :
                   (sclk_fall && !cs_s) ? {out_r[22:0], 1'b0} : out_r;

  // Output side registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_frame_r  <= 24'h000000;
      out_r        <= 24'h000000;
      sdo_r        <= 1'b0;
      read_power_r <= 1'b0;
    end else begin
      out_frame_r  <= out_frame_nxt;
      out_r        <= out_nxt;
      sdo_r        <= out_r[23];
      read_power_r <= read_power_nxt;
    end
  end

  assign sdo                = sdo_r;
  assign wiper_terminal_ch1 = wiper_r[0];
  assign wiper_terminal_ch2 = wiper_r[1];
  assign read_power         = read_power_r;

  // Checks on the decoder
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_cmd(logic [3:0] c, logic [3:0] a);
    exec && !restore_all && frm.cmd == c && frm.addr == a;
  endsequence
  // Frame start loads the transmit register, then its MSB reaches the pin
  sequence s_frame_load;
    out_r == out_frame_r ##1 sdo_r == out_frame_r[23];
  endsequence

  property p_write;
    s_cmd(dial_pkg::CMD_WRITE, 4'h0) |=> wiper_r[0] == in_r[9:0];
  endproperty
  a_write: assert property (p_write) else $error("wiper write lost");
  property p_inc;
    s_cmd(dial_pkg::CMD_INC, 4'h0) ##0 wiper_r[0] != dial_pkg::WIPER_FULL
      |=> wiper_r[0] == $past(wiper_r[0]) + 10'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_inc_sat;
    s_cmd(dial_pkg::CMD_INC, 4'h1) ##0 wiper_r[1] == dial_pkg::WIPER_FULL
      |=> wiper_r[1] == dial_pkg::WIPER_FULL;
  endproperty
  a_inc_sat: assert property (p_inc_sat) else $error("inc wrapped");
  property p_store;
    s_cmd(dial_pkg::CMD_STORE, 4'h0) ##0 wp_ok
      |=> nv_wiper_r[0] == $past(wiper_r[0]);
  endproperty
  a_store: assert property (p_store) else $error("store lost");
  property p_protect;
    !wp_ok |=> $stable(nv_wiper_r[0]) && $stable(nv_user_r[0]);
  endproperty
  a_protect: assert property (p_protect) else $error("wp ignored");
  property p_strobe;
    pr_fall |=> wiper_r[0] == $past(nv_wiper_r[0]) &&
                wiper_r[1] == $past(nv_wiper_r[1]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe restore");
  property p_restore;
    s_cmd(dial_pkg::CMD_RESTORE, 4'h1) |=> wiper_r[1] == $past(nv_wiper_r[1]);
  endproperty
  a_restore: assert property (p_restore) else $error("restore lost");
  property p_double;
    s_cmd(dial_pkg::CMD_DOUBLE, 4'h1) ##0 !wiper_r[1][9]
      |=> wiper_r[1] == {$past(wiper_r[1][8:0]), 1'b0};
  endproperty
  a_double: assert property (p_double) else $error("double wrong");
  property p_mid;
    s_cmd(dial_pkg::CMD_DOUBLE, 4'h0) ##0 wiper_r[0] == dial_pkg::WIPER_MID
      |=> wiper_r[0] == dial_pkg::WIPER_FULL;
  endproperty
  a_mid: assert property (p_mid) else $error("midscale overflow");
  property p_user;
    s_cmd(dial_pkg::CMD_STORE_USER, 4'h2) ##0 wp_ok
      |=> nv_user_r[0] == in_r[15:0];
  endproperty
  a_user: assert property (p_user) else $error("user write lost");
  property p_rb_wiper;
    s_cmd(dial_pkg::CMD_READ_WIPER, 4'h0)
      |=> out_frame_r == {in_r[23:16], 6'h00, $past(wiper_r[0])};
  endproperty
  a_rb_wiper: assert property (p_rb_wiper) else $error("wiper rb");
  property p_echo;
    exec && !rb_cmd |=> out_frame_r == in_r ##1 $stable(out_frame_r);
  endproperty
  a_echo: assert property (p_echo) else $error("echo wrong");
  property p_sdo;
    cs_fall |=> s_frame_load;
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo first bit");
  property p_nop;
    exec && frm.cmd == dial_pkg::CMD_NOP |=> !read_power_r;
  endproperty
  a_nop: assert property (p_nop) else $error("nop power");
  property p_len;
    cs_rise && cnt_r != dial_pkg::FRAME_CNT && !restore_all
      |=> $stable(out_frame_r) && $stable(wiper_r[0]);
  endproperty
  a_len: assert property (p_len) else $error("short frame acted");

endmodule
`default_nettype wire

// ==== testbench/serial_host.sv ====
`default_nettype none
module serial_host (
  // Link to the device
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half period of the 80 ns link clock
  localparam int HALF = 40;

  // Idle link: clock parked low, device deselected
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi  = 1'h0;
  end

  // One frame of n clocks, MSB first; clocks past 24 send the inverse
  // of the last bit, so an overlong frame can be issued on purpose
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    int i;
    rx   = 24'h000000;
    cs_n = 1'h0;
    sdi  = tx[23];
    #HALF;
    for (i = 0; i < n; i++) begin
      // Sample the device at the rise, launch our next bit on the fall
      sclk = 1'h1;
      rx   = {rx[22:0], sdo};
      #HALF;
      sclk = 1'h0;
      sdi  = (i < 23) ? tx[22 - i] : ~tx[0];
      #HALF;
    end
    // Deselect; the gap also lets the device act before the next frame
    cs_n = 1'h1;
    #(3 * HALF);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_dual_wiper_serial_command_decoder.sv ====
`default_nettype none
module tb_dual_wiper_serial_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  // Pins of the device
  logic        clock;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        write_protect_n;
  logic        restore_strobe_n;
  logic [9:0]  wiper_ch1;
  logic [9:0]  wiper_ch2;
  logic        read_power;
  // Expected device state
  logic [9:0]  w_exp [2];
  logic [9:0]  slot_exp [2];
  logic [15:0] user_exp [16];
  logic [23:0] prev_exp;
  logic        rp_exp;
  // Bookkeeping
  int          err_count;
  int          num_checks;
  int          seed;
  int          k;
  logic [23:0] rx;
  logic [3:0]  rnd_cmd [5];

  dual_wiper_serial_command_decoder dut (
    .clock              (clock),
    .rst                (rst),
    .sclk               (sclk),
    .cs_n               (cs_n),
    .sdi                (sdi),
    .sdo                (sdo),
    .write_protect_n    (write_protect_n),
    .restore_strobe_n   (restore_strobe_n),
    .wiper_terminal_ch1 (wiper_ch1),
    .wiper_terminal_ch2 (wiper_ch2),
    .read_power         (read_power)
  );

  serial_host host (
    .sclk (sclk),
    .cs_n (cs_n),
    .sdi  (sdi),
    .sdo  (sdo)
  );

  // 200 MHz system clock
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk_frame(input string what, input logic [23:0] exp,
                           input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [9:0] exp,
                         input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Wiper arithmetic: load, saturating step, saturating double, reload
  function automatic logic [9:0] step_wiper(input dial_pkg::frame_t f,
    input logic [9:0] cur, input logic [9:0] nv);
    case (f.cmd)
      dial_pkg::CMD_WRITE:   return f.data[9:0];
      dial_pkg::CMD_INC:     return (cur == dial_pkg::WIPER_FULL) ?
                               cur : cur + 10'h001;
      dial_pkg::CMD_DOUBLE:  return cur[9] ? dial_pkg::WIPER_FULL :
                               {cur[8:0], 1'h0};
      dial_pkg::CMD_RESTORE: return nv;
      default:               return cur;
    endcase
  endfunction

  // Advance the expected state by one accepted frame
  task automatic model(input dial_pkg::frame_t f);
    logic        ch;
    logic        ok;
    logic [15:0] word;
    ch   = f.addr[0];
    ok   = (f.addr < 4'h2);
    word = ok ? {6'h00, slot_exp[ch]} : user_exp[f.addr];
    prev_exp = f;
    if (ok && write_protect_n && f.cmd == dial_pkg::CMD_STORE)
      slot_exp[ch] = w_exp[ch];
    if (ok)
      w_exp[ch] = step_wiper(f, w_exp[ch], slot_exp[ch]);
    if (write_protect_n && f.cmd == dial_pkg::CMD_STORE_USER &&
        f.addr >= dial_pkg::USER_BASE && f.addr != 4'hF)
      user_exp[f.addr] = f.data;
    if (f.cmd == dial_pkg::CMD_READ_NV)
      prev_exp = {f.cmd, f.addr, word};
    if (f.cmd == dial_pkg::CMD_READ_WIPER)
      prev_exp = {f.cmd, f.addr, 6'h00, ok ? w_exp[ch] : 10'h000};
    if (f.cmd inside {dial_pkg::CMD_RESTORE, dial_pkg::CMD_READ_NV,
                      dial_pkg::CMD_READ_WIPER})
      rp_exp = 1'h1;
    if (f.cmd == dial_pkg::CMD_NOP)
      rp_exp = 1'h0;
  endtask

  // One full frame, then echo, wipers and power state compared
  task automatic send(input dial_pkg::frame_t f);
    @(negedge clock);
    host.xfer(f, 24, rx);
    chk_frame("sdo frame", prev_exp, rx);
    model(f);
    chk_val("wiper ch1", w_exp[0], wiper_ch1);
    chk_val("wiper ch2", w_exp[1], wiper_ch2);
    chk_val("read power", {9'h000, rp_exp}, {9'h000, read_power});
  endtask

  // Hang guard
  initial begin
    #400000;
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    seed = 42;
    err_count = 0;
    num_checks = 0;
    rst = 1'h1;
    write_protect_n = 1'h1;
    restore_strobe_n = 1'h1;
    w_exp = '{dial_pkg::NV_WIPER_RST, dial_pkg::NV_WIPER_RST};
    slot_exp = '{dial_pkg::NV_WIPER_RST, dial_pkg::NV_WIPER_RST};
    user_exp = '{default: dial_pkg::NV_USER_RST};
    prev_exp = 24'h000000;
    rp_exp = 1'h0;
    rnd_cmd = '{dial_pkg::CMD_WRITE, dial_pkg::CMD_INC, dial_pkg::CMD_DOUBLE,
                dial_pkg::CMD_NOP, dial_pkg::CMD_READ_WIPER};
    repeat (8) @(negedge clock);
    rst = 1'h0;
    repeat (4) @(negedge clock);
    chk_val("boot ch1", dial_pkg::NV_WIPER_RST, wiper_ch1);
    chk_val("boot ch2", dial_pkg::NV_WIPER_RST, wiper_ch2);
    $display("Test boot restore done");
    send(24'hB00100);
    send(24'hB10200);
    send(24'hE00000);
    send(24'hE00000);
    send(24'hB003FF);
    send(24'hE01234);
    $display("Test write and step done");
    send(24'hB00155);
    send(24'h200000);
    send(24'hB00000);
    send(24'h100000);
    // Move channel 2 off its slot so its reload is visible
    send(24'hB10123);
    send(24'h110000);
    send(24'h000000);
    @(negedge clock);
    write_protect_n = 1'h0;
    send(24'hB00077);
    send(24'h200000);
    send(24'h3E1111);
    send(24'h100000);
    send(24'h9E0000);
    @(negedge clock);
    write_protect_n = 1'h1;
    send(24'h000000);
    $display("Test store and protect done");
    send(24'h32AAAA);
    send(24'h335555);
    send(24'h3EBEEF);
    send(24'h920000);
    send(24'h930000);
    send(24'h9E0000);
    send(24'h900000);
    send(24'h000000);
    send(24'hB00200);
    send(24'hC00000);
    send(24'hA00000);
    send(24'h000000);
    send(24'hB101FF);
    send(24'hC10000);
    send(24'hC10000);
    send(24'hE1ABCD);
    $display("Test readback and double done");
    // Frames one clock short and one clock long are dropped
    for (k = 23; k <= 25; k += 2) begin
      @(negedge clock);
      host.xfer(24'hB00001, k, rx);
      chk_val("odd length ch1", w_exp[0], wiper_ch1);
    end
    send(24'hA10000);
    for (k = 0; k < 40; k++) begin
      send({rnd_cmd[$unsigned($random(seed)) % 5], 3'h0,
            1'($random(seed)), 16'($random(seed))});
    end
    $display("Test random frames done");
    send(24'hB00011);
    send(24'hB10022);
    @(negedge clock);
    restore_strobe_n = 1'h0;
    repeat (8) @(negedge clock);
    restore_strobe_n = 1'h1;
    repeat (8) @(negedge clock);
    chk_val("strobe ch1", slot_exp[0], wiper_ch1);
    chk_val("strobe ch2", slot_exp[1], wiper_ch2);
    $display("Test restore strobe done");
    end_of_test();
  end
endmodule
`default_nettype wire
